// *** mrc_pkg.sv ***
// package: constants and types for the reset sequencer
package mrc_pkg;
  // ==================================================
  // clock and timing
  localparam int unsigned CLK_HZ             = 20000000;
  localparam int unsigned LOW_SUPPLY_MIN_US  = 1000;
  localparam int unsigned LOW_SUPPLY_MIN_CYC = (CLK_HZ / 1000000) * LOW_SUPPLY_MIN_US + 1;
  localparam int unsigned RESET_DELAY_US     = 1000;
  localparam int unsigned RESET_DELAY_CYC    = (CLK_HZ / 1000000) * RESET_DELAY_US;
  localparam int unsigned CNT_W              = 16;
  // ==================================================
  // reset values
  localparam logic [12:0] PC_RESET    = 13'h0000;
  localparam logic [2:0]  SP_TOP      = 3'h0;
  localparam logic [7:0]  PORT_RESET  = 8'hFF;
  localparam logic [7:0]  DIR_RESET   = 8'hFF;
  // ==================================================
  // types
  typedef enum logic [1:0] {
    MRC_SRC_NONE,
    MRC_SRC_PIN,
    MRC_SRC_LOWSUP,
    MRC_SRC_WDOG
  } mrc_src_t;
  typedef enum {
    MRC_HOLD,
    MRC_DELAY,
    MRC_RUN
  } mrc_state_t;
endpackage : mrc_pkg

// *** mrc_sync.sv ***
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/100ps
module mrc_sync (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic rstVal,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic meta_q;
  logic meta_d;
  logic sync_d;

  always_comb begin
    meta_d = asyncIn;
    sync_d = meta_q;
  end

  // rstVal left unused: async reset takes constants only, so both flops clear low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q  <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      meta_q  <= meta_d;
      syncOut <= sync_d;
    end
  end
endmodule : mrc_sync

// *** mrc_lowsup_filter.sv ***
// low-supply glitch filter: fires only for lows lasting past the minimum time
`timescale 1ns/100ps
module mrc_lowsup_filter
  import mrc_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic enable,
  input  wire logic lowSync,
  output logic      lowReset
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             lowReset_d;

  always_comb begin
    cnt_d      = cnt_q;
    lowReset_d = 1'b0;
    if (!enable || !lowSync) begin
      cnt_d = '0;
    end else if (cnt_q < CNT_W'(LOW_SUPPLY_MIN_CYC)) begin
      cnt_d = cnt_q + 1'b1;
    end else begin
      lowReset_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q    <= '0;
      lowReset <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      lowReset <= lowReset_d;
    end
  end
endmodule : mrc_lowsup_filter

// *** mcu_reset_controller.sv ***
// top: merges reset sources, stretches them and drives core reset controls
`timescale 1ns/100ps
module mcu_reset_controller
  import mrc_pkg::*;
#(
  parameter int unsigned DELAY_CYC = RESET_DELAY_CYC
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic ext_reset_n,
  input  wire logic lowSupplyDetect,
  input  wire logic lowSupplyEnable,
  input  wire logic watchdogExpired,
  input  wire logic poweredDown,
  input  wire logic powerdownSet,
  input  wire logic watchdogClear,
  output logic      coreRun,
  output logic      fullReset,
  output logic      pcStackReset,
  output logic      portReset,
  output logic      watchdog_timeout_flag,
  output logic      powerdown_flag,
  output logic      low_supply_reset,
  output logic      startup_timer_busy
);
  import mrc_pkg::*;

  // ==================================================
  // input conditioning
  logic extNSync;
  logic lowSync;
  logic wdSync;
  logic pdSync;
  logic lowRst;

  mrc_sync uExtSync (
    .clk     (clk),
    .resetn  (resetn),
    .rstVal  (1'b0),
    .asyncIn (ext_reset_n),
    .syncOut (extNSync)
  );
  mrc_sync uLowSync (
    .clk     (clk),
    .resetn  (resetn),
    .rstVal  (1'b0),
    .asyncIn (lowSupplyDetect),
    .syncOut (lowSync)
  );
  mrc_sync uWdSync (
    .clk     (clk),
    .resetn  (resetn),
    .rstVal  (1'b0),
    .asyncIn (watchdogExpired),
    .syncOut (wdSync)
  );
  mrc_sync uPdSync (
    .clk     (clk),
    .resetn  (resetn),
    .rstVal  (1'b0),
    .asyncIn (poweredDown),
    .syncOut (pdSync)
  );

  mrc_lowsup_filter uLowFilt (
    .clk      (clk),
    .resetn   (resetn),
    .enable   (lowSupplyEnable),
    .lowSync  (lowSync),
    .lowReset (lowRst)
  );

  // ==================================================
  // sequencer
  mrc_state_t       state_q;
  mrc_state_t       state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             full_q;
  logic             full_d;
  logic             pcOnly_q;
  logic             pcOnly_d;
  logic             por_q;
  logic             por_d;
  logic             toFlag_d;
  logic             pdFlag_d;
  logic             run_d;
  logic             fullRst_d;
  logic             pcRst_d;
  logic             portRst_d;
  logic             wdEvt;
  logic             anyFull;

  // watchdog event while powered down is the light reset
  always_comb begin
    wdEvt   = wdSync && (state_q == MRC_RUN);
    anyFull = !extNSync || lowRst || (wdEvt && !pdSync);
  end

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    full_d    = full_q;
    pcOnly_d  = pcOnly_q;
    por_d     = por_q;
    toFlag_d  = watchdog_timeout_flag;
    pdFlag_d  = powerdown_flag;
    // clear first, sets after it: a set in the same cycle wins
    if (watchdogClear) begin
      toFlag_d = 1'b0;
      pdFlag_d = 1'b0;
    end
    if (powerdownSet) begin
      pdFlag_d = 1'b1;
    end
    if (wdEvt) begin
      toFlag_d = 1'b1;
      if (pdSync) begin
        pdFlag_d = 1'b1;
      end
    end
    // pin and low-supply sources leave flags alone
    unique case (state_q)
      MRC_HOLD: begin
        cnt_d = '0;
        if (extNSync && !lowRst) begin
          state_d = MRC_DELAY;
        end
      end
      MRC_DELAY: begin
        if (anyFull) begin
          // a full source during a light (power-down) delay upgrades it
          state_d  = MRC_HOLD;
          full_d   = 1'b1;
          pcOnly_d = 1'b0;
          cnt_d    = '0;
        end else if (cnt_q >= CNT_W'(DELAY_CYC - 1)) begin
          state_d = MRC_RUN;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      MRC_RUN: begin
        if (anyFull) begin
          state_d  = MRC_HOLD;
          full_d   = 1'b1;
          pcOnly_d = 1'b0;
        end else if (wdEvt) begin
          state_d  = MRC_DELAY;
          full_d   = 1'b0;
          pcOnly_d = 1'b1;
          cnt_d    = '0;
        end else begin
          full_d   = 1'b0;
          pcOnly_d = 1'b0;
          por_d    = 1'b0;
        end
      end
    endcase
    run_d     = (state_d == MRC_RUN);
    fullRst_d = (state_d != MRC_RUN) && full_d;
    pcRst_d   = (state_d != MRC_RUN);
    // ports preset only at power-on; running resets keep them
    portRst_d = (state_d != MRC_RUN) && por_d;
  end

  // power-on: flags cleared, full reset, ports preset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q               <= MRC_HOLD;
      cnt_q                 <= '0;
      full_q                <= 1'b1;
      pcOnly_q              <= 1'b0;
      por_q                 <= 1'b1;
      watchdog_timeout_flag <= 1'b0;
      powerdown_flag        <= 1'b0;
      coreRun               <= 1'b0;
      fullReset             <= 1'b1;
      pcStackReset          <= 1'b1;
      portReset             <= 1'b1;
      low_supply_reset      <= 1'b0;
      startup_timer_busy    <= 1'b0;
    end else begin
      state_q               <= state_d;
      cnt_q                 <= cnt_d;
      full_q                <= full_d;
      pcOnly_q              <= pcOnly_d;
      por_q                 <= por_d;
      watchdog_timeout_flag <= toFlag_d;
      powerdown_flag        <= pdFlag_d;
      coreRun               <= run_d;
      fullReset             <= fullRst_d;
      pcStackReset          <= pcRst_d;
      portReset             <= portRst_d;
      low_supply_reset      <= lowRst;
      startup_timer_busy    <= (state_d == MRC_DELAY);
    end
  end
endmodule : mcu_reset_controller

// *** mrc_asserts.sv ***
// checker: port-level properties of the reset sequencer
`timescale 1ns/100ps
module mrc_asserts
  import mrc_pkg::*;
#(parameter int unsigned DELAY_CYC = 10) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ext_reset_n,
  input wire logic lowSupplyDetect,
  input wire logic lowSupplyEnable,
  input wire logic watchdogExpired,
  input wire logic poweredDown,
  input wire logic powerdownSet,
  input wire logic watchdogClear,
  input wire logic coreRun,
  input wire logic fullReset,
  input wire logic pcStackReset,
  input wire logic portReset,
  input wire logic watchdog_timeout_flag,
  input wire logic powerdown_flag,
  input wire logic low_supply_reset,
  input wire logic startup_timer_busy
);
  // ======
  // run-length counters, saturating so long runs never wrap
  logic [15:0] hiCnt_q, hiCnt_d, lowCnt_q, lowCnt_d;
  always_comb begin
    hiCnt_d  = ext_reset_n ? hiCnt_q + 16'(hiCnt_q != 16'hFFFF) : 16'h0;
    lowCnt_d = (lowSupplyDetect && lowSupplyEnable) ? lowCnt_q + 16'(lowCnt_q != 16'hFFFF) : 16'h0;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hiCnt_q  <= 16'h0;
      lowCnt_q <= 16'h0;
    end else begin
      hiCnt_q  <= hiCnt_d;
      lowCnt_q <= lowCnt_d;
    end
  end
  // ======
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_pin_halts: assert property (!ext_reset_n[*5] |=> !coreRun)
    else $error("core runs with reset pin low");
  chk_pin_clears: assert property (!ext_reset_n[*5] |=> pcStackReset && fullReset)
    else $error("pin reset not applied");
  chk_delay_len: assert property ($rose(coreRun) |-> hiCnt_q >= DELAY_CYC)
    else $error("run resumed before start-up delay");
  chk_por_flags: assert property ($rose(resetn) |-> portReset && !watchdog_timeout_flag && !powerdown_flag)
    else $error("power-on state wrong");
  chk_flags_kept: assert property (!ext_reset_n && !powerdownSet && !watchdogClear && !watchdogExpired
    |=> $stable(watchdog_timeout_flag) && $stable(powerdown_flag))
    else $error("pin reset changed flags");
  chk_wdog_run: assert property (coreRun && !poweredDown && watchdogExpired
    ##1 watchdogExpired[*2] |-> ##[0:6] (watchdog_timeout_flag && !coreRun))
    else $error("watchdog reset missing");
  chk_wdog_down: assert property (coreRun && poweredDown && watchdogExpired
    ##1 watchdogExpired[*2] |-> ##[0:6] (pcStackReset && watchdog_timeout_flag && powerdown_flag))
    else $error("power-down watchdog reset wrong");
  chk_low_filter: assert property ($rose(low_supply_reset) |-> lowCnt_q >= LOW_SUPPLY_MIN_CYC)
    else $error("short low supply not ignored");
  chk_low_full: assert property (low_supply_reset |-> ##[0:4] (fullReset && !coreRun))
    else $error("low supply reset not full");
  chk_timer_hold: assert property (startup_timer_busy |-> !coreRun)
    else $error("core runs during start-up delay");
  cover property ($rose(coreRun));
  cover property ($rose(low_supply_reset));
  cover property (poweredDown && $rose(pcStackReset));
endmodule : mrc_asserts
bind mcu_reset_controller mrc_asserts #(.DELAY_CYC(DELAY_CYC)) uChk (.*);

// *** mrc_rc_model.sv ***
// model of the external rc network and reset switch on the pin
`timescale 1ns/100ps
module mrc_rc_model #(parameter int unsigned RC_CYC = 8) (
  input  wire logic clk,
  input  wire logic press,
  output logic      ext_reset_n
);
  int unsigned chargeCnt = 0;
  // capacitor recharges only with the switch open, so the pin lags each release
  // sampled on the rising edge so the bench's falling-edge press never races it
  always @(posedge clk) begin
    if (press) chargeCnt <= 0;
    else if (chargeCnt < RC_CYC) chargeCnt <= chargeCnt + 1;
  end
  assign ext_reset_n = !press && (chargeCnt >= RC_CYC);
endmodule : mrc_rc_model

// *** mcu_reset_controller_bench.sv ***
// self-checking bench for the reset sequencer
`timescale 1ns/100ps
module mcu_reset_controller_bench;
  import mrc_pkg::*;
  localparam int unsigned DLY = 10;
  logic clk = 0, resetn = 0, press = 0, lowSupplyDetect = 0, lowSupplyEnable = 1, watchdogExpired = 0;
  logic poweredDown = 0, powerdownSet = 0, watchdogClear = 0, ext_reset_n, coreRun, fullReset, pcStackReset;
  logic portReset, watchdog_timeout_flag, powerdown_flag, low_supply_reset, startup_timer_busy;
  logic [15:0] noteQ[$];
  int errors = 0, n_compared = 0, seed = 11490, i, len;
  // bit order: run, full, pc/stack, port, timeout, powerdown, low supply, busy
  wire [7:0] outs = {coreRun, fullReset, pcStackReset, portReset, watchdog_timeout_flag, powerdown_flag,
                     low_supply_reset, startup_timer_busy};
  mcu_reset_controller #(.DELAY_CYC(DLY)) uut (.*);
  mrc_rc_model rc (.clk(clk), .press(press), .ext_reset_n(ext_reset_n));
  initial forever #25 clk = ~clk;
  // ======
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %b want %b", $time, seen, exp);
    end
  endtask : check
  task automatic note(logic [7:0] mask, logic [7:0] val);
    noteQ.push_back({mask, val});
    @(negedge clk);
  endtask : note
  // one step past the edge, so a note pushed at this same edge is seen
  always @(negedge clk) begin
    #1;
    if (noteQ.size() > 0) begin
      check(outs & noteQ[0][15:8], noteQ[0][7:0]);
      void'(noteQ.pop_front());
    end
  end
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic waitRun(int lim);
    for (i = 0; i < lim && coreRun !== 1'b1; i++) @(negedge clk);
    check(8'(coreRun), 8'h1);
  endtask : waitRun
  task automatic pulseWdog();
    watchdogExpired = 1;
    cyc(3);
    watchdogExpired = 0;
  endtask : pulseWdog
  task automatic print_verdict;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // ======
  initial begin
    cyc(6);
    resetn = 1;
    note(8'hFC, 8'h70);
    waitRun(60);
    note(8'hE0, 8'h80);
    $display("power-on test done");
    powerdownSet = 1;
    cyc(1);
    powerdownSet = 0;
    cyc(3);
    press = 1;
    cyc(8);
    note(8'hFC, 8'h64);
    press = 0;
    waitRun(80);
    check(8'(i >= 8 + DLY), 8'h1);
    $display("pin test done");
    pulseWdog();
    cyc(3);
    note(8'hEC, 8'h6C);
    waitRun(60);
    watchdogClear = 1;
    cyc(1);
    watchdogClear = 0;
    poweredDown = 1;
    powerdownSet = 1;
    cyc(1);
    powerdownSet = 0;
    cyc(3);
    pulseWdog();
    cyc(2);
    note(8'h6D, 8'h2D);
    poweredDown = 0;
    waitRun(60);
    $display("watchdog test done");
    len = 1000 + ($random(seed) & 16'h3FFF);
    lowSupplyDetect = 1;
    cyc(len);
    lowSupplyDetect = 0;
    cyc(4);
    note(8'h82, 8'h80);
    lowSupplyDetect = 1;
    cyc(LOW_SUPPLY_MIN_CYC + 4);
    note(8'hCE, 8'h4E);
    lowSupplyDetect = 0;
    waitRun(80);
    $display("low supply test done");
    print_verdict();
  end
  initial begin
    #(50 * 60000);
    errors++;
    print_verdict();
  end
endmodule : mcu_reset_controller_bench
